// ==== verilog/oscsw_top.sv ====
// oscillator switch, doze divider and rc trim with apb registers
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// RULE1: lock bit with monitor enabled blocks source changes; no lock otherwise
// RULE2: pll status is 1 in lock, 0 when unlocked or disabled
// RULE3: pll status forced 0 at valid switch and in non-pll modes
// RULE4: clock fail flag set on monitor failure report
// RULE5: secondary oscillator runs while its enable bit is 1
// RULE6: switch request starts switch to new source, reads 0 when done
// RULE7: recover-on-interrupt lets interrupts clear doze enable
// RULE8: doze code n gives cpu to peripheral ratio 1:2^n
// RULE9: doze ratio applies only while doze enable is 1
// RULE10: postscaler codes divide by 1..64, code 7 by 256, reset 001
// RULE11: six-bit two's complement rc trim, zero is centre
// RULE12: switching allowed only with switch fuse bit at 0
// RULE13: switching disabled: fuse source shown, request ignored and reads 0
// RULE14: primary submode comes only from configuration fuses
// RULE15: high byte write needs keys 78h then 9Ah right before
// RULE16: low byte write needs keys 46h then 57h right before
// RULE17: equal current and new source aborts and clears request
// RULE18: valid switch start clears pll status and fail flag
// RULE19: start new source, wait start-up timer and pll lock
// RULE20: wait 10 cycles, switch, clear request, copy new to current
// RULE21: old source off, except low-power oscillator in use or enabled secondary
// RULE22: software must go via plain rc between the two pll modes
// RULE23: three-bit source encoding 000 plain rc to 111 divided rc
// RULE24: fail monitor enabled only with both switch fuses at 0
// RULE25: any other write cancels a pending unlock; writes to unmapped addresses leave it pending
module oscsw_top (
    input  wire logic                 pclk,     // 10 mhz bus clock
    input  wire logic                 presetn,  // async reset, low
    input  wire logic                 psel,     // apb select
    input  wire logic                 penable,  // apb access phase
    input  wire logic                 pwrite,   // apb direction
    input  wire logic [7:0]           paddr,    // apb byte address
    input  wire logic [31:0]          pwdata,   // apb write data
    input  wire logic [3:0]           pstrb,    // apb byte lanes
    output logic      [31:0]          prdata,   // apb read data
    output logic                      pready,   // apb ready
    output logic                      pslverr,  // unmapped address
    input  wire oscsw_pkg::oscsw_pins_t pins,   // fuses, analog status
    input  wire logic                 irq_event, // interrupt, pclk domain
    output oscsw_pkg::oscsw_clk_t     clk_ctrl  // clock controls
);
    typedef enum logic [4:0] {
        UL_IDLE  = 5'b00001,
        UL_HKEY  = 5'b00010,
        UL_HOPEN = 5'b00100,
        UL_LKEY  = 5'b01000,
        UL_LOPEN = 5'b10000
    } oscsw_ul_t;
    typedef enum logic [3:0] {
        SW_IDLE   = 4'b0001,
        SW_CHECK  = 4'b0010,
        SW_READY  = 4'b0100,
        SW_SETTLE = 4'b1000
    } oscsw_sw_t;

    localparam int PW = $bits(oscsw_pkg::oscsw_pins_t);

    // RULE23 source code decode
    function automatic logic [5:0] src_mask(input logic [2:0] s);
        logic [5:0] m;
        m = 6'h00;
        unique case (s)
            oscsw_pkg::SRC_RC, oscsw_pkg::SRC_RC_DIV:
                m[oscsw_pkg::EN_RC] = 1'b1;
            oscsw_pkg::SRC_RC_PLL: begin
                m[oscsw_pkg::EN_RC] = 1'b1;
                m[oscsw_pkg::EN_PLL] = 1'b1;
            end
            oscsw_pkg::SRC_PRI: m[oscsw_pkg::EN_PRI] = 1'b1;
            oscsw_pkg::SRC_PRI_PLL: begin
                m[oscsw_pkg::EN_PRI] = 1'b1;
                m[oscsw_pkg::EN_PLL] = 1'b1;
            end
            oscsw_pkg::SRC_SEC: m[oscsw_pkg::EN_SEC] = 1'b1;
            oscsw_pkg::SRC_LP_OSC: m[oscsw_pkg::EN_LP_OSC] = 1'b1;
            oscsw_pkg::SRC_LP_RC_DIV: m[oscsw_pkg::EN_LP_RC] = 1'b1;
        endcase
        return m;
    endfunction

    // three-stage pin synchronisers, change accepted when 2nd and 3rd agree
    logic [PW-1:0] sy1_q, sy2_q, sy3_q, pinf_q;
    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sy1_q[gi]  <= 1'b0;
                    sy2_q[gi]  <= 1'b0;
                    sy3_q[gi]  <= 1'b0;
                    pinf_q[gi] <= 1'b0;
                end else begin
                    sy1_q[gi] <= pins[gi];
                    sy2_q[gi] <= sy1_q[gi];
                    sy3_q[gi] <= sy2_q[gi];
                    if (sy2_q[gi] == sy3_q[gi])
                        pinf_q[gi] <= sy3_q[gi];
                end
            end
        end
    endgenerate
    oscsw_pkg::oscsw_pins_t pin_s;
    assign pin_s = pinf_q;

    // state
    oscsw_ul_t  ul_q, ul_d;
    oscsw_sw_t  sw_q, sw_d;
    logic [2:0] cur_q, new_q;
    logic       lock_q, pll_st_q, fail_q, sec_en_q, req_q, fail_seen_q;
    logic       recov_q, doze_enable_q;
    logic [2:0] doze_q, post_q;
    logic [5:0] trim_q;
    logic [3:0] settle_q;
    logic [2:0] boot_q;
    logic       boot_done;
    oscsw_pkg::oscsw_clk_t clk_d;

    // fuse-derived modes
    logic sw_allowed, mon_en, sel_locked;
    // RULE12 switching fuse
    assign sw_allowed = ~pin_s.switch_monitor_fuses[1] & boot_done;
    // RULE24 monitor needs both fuses
    assign mon_en     = (pin_s.switch_monitor_fuses == 2'b00) & boot_done;
    // RULE1 lock only counts with monitor
    assign sel_locked = lock_q & mon_en;
    assign boot_done  = (boot_q == 3'(oscsw_pkg::BOOT_CYCLES));

    // apb decode
    logic acc, wr_en, hit_osc, hit_div, hit_trm, mapped;
    assign hit_osc = (paddr == oscsw_pkg::OFS_OSC_CTRL);
    assign hit_div = (paddr == oscsw_pkg::OFS_CLK_DIV);
    assign hit_trm = (paddr == oscsw_pkg::OFS_RC_TUNE);
    assign mapped  = hit_osc | hit_div | hit_trm;
    assign acc     = psel & penable;
    assign wr_en   = acc & pwrite & mapped;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // key detection on the oscillator_control byte lanes
    logic wr_osc_h, wr_osc_l, key_h1, key_h2, key_l1, key_l2;
    logic acc_hi, acc_lo;
    assign wr_osc_h = wr_en & hit_osc & pstrb[1];
    assign wr_osc_l = wr_en & hit_osc & pstrb[0];
    assign key_h1 = wr_osc_h & (pwdata[15:8] == oscsw_pkg::KEY_HIGH_1);
    assign key_h2 = wr_osc_h & (pwdata[15:8] == oscsw_pkg::KEY_HIGH_2);
    assign key_l1 = wr_osc_l & (pwdata[7:0] == oscsw_pkg::KEY_LOW_1);
    assign key_l2 = wr_osc_l & (pwdata[7:0] == oscsw_pkg::KEY_LOW_2);
    // RULE15 high byte opens after keys
    assign acc_hi = (ul_q == UL_HOPEN) & wr_osc_h;
    // RULE16 low byte opens after keys
    assign acc_lo = (ul_q == UL_LOPEN) & wr_osc_l;

    // unlock sequencer, advanced by every register write
    always_comb begin
        ul_d = ul_q;
        if (wr_en) begin
            // RULE25 wrong or late write cancels
            unique case (ul_q)
                UL_IDLE, UL_HOPEN, UL_LOPEN:
                    ul_d = key_h1 ? UL_HKEY : (key_l1 ? UL_LKEY : UL_IDLE);
                UL_HKEY: ul_d = key_h2 ? UL_HOPEN : UL_IDLE;
                UL_LKEY: ul_d = key_l2 ? UL_LOPEN : UL_IDLE;
            endcase
        end
    end

    // switch sequencer
    logic need_xtal, need_pll, tgt_ready, sw_start, sw_done, sw_abort, req_wr;
    logic [5:0] new_mask;
    assign new_mask  = src_mask(new_q);
    assign need_xtal = new_mask[oscsw_pkg::EN_PRI] &
        (pin_s.primary_submode_fuses != oscsw_pkg::SUB_EXT_CLOCK);
    assign need_pll = new_mask[oscsw_pkg::EN_PLL];
    // RULE19 wait start-up timer and lock
    assign tgt_ready = (~need_xtal | pin_s.osc_startup_done) &
                       (~need_pll | pin_s.pll_in_lock);
    // RULE17 redundant request aborts
    assign sw_abort = (sw_q == SW_CHECK) & (new_q == cur_q);
    assign sw_start = (sw_q == SW_CHECK) & (new_q != cur_q);
    assign sw_done  = (sw_q == SW_SETTLE) &
        (settle_q == 4'(oscsw_pkg::SETTLE_CYCLES - 1));
    // RULE6 request taken only through the low byte
    assign req_wr = acc_lo & pwdata[oscsw_pkg::REQ_BIT] & sw_allowed &
                    ~sel_locked & (sw_q == SW_IDLE);

    always_comb begin
        sw_d = sw_q;
        unique case (sw_q)
            SW_IDLE:   if (req_q) sw_d = SW_CHECK;
            SW_CHECK:  sw_d = sw_abort ? SW_IDLE : SW_READY;
            SW_READY:  if (tgt_ready) sw_d = SW_SETTLE;
            SW_SETTLE: if (sw_done) sw_d = SW_IDLE;
        endcase
    end

    // boot capture of fuses, sequencer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q   <= 3'h0;
            ul_q     <= UL_IDLE;
            sw_q     <= SW_IDLE;
            settle_q <= 4'h0;
        end else begin
            if (!boot_done)
                boot_q <= boot_q + 3'h1;
            ul_q     <= ul_d;
            sw_q     <= sw_d;
            // RULE20 count ten settle cycles
            settle_q <= (sw_q == SW_SETTLE) ? settle_q + 4'h1 : 4'h0;
        end
    end

    // oscillator_control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= oscsw_pkg::SRC_RST;
            new_q <= oscsw_pkg::SRC_RST;
            lock_q <= 1'b0;
            sec_en_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            if (boot_q == 3'(oscsw_pkg::BOOT_CYCLES - 1) || !sw_allowed) begin
                // RULE13 fuse source shown while disabled
                cur_q <= pin_s.initial_source_fuses;
                if (boot_q == 3'(oscsw_pkg::BOOT_CYCLES - 1))
                    new_q <= pin_s.initial_source_fuses;
                req_q <= 1'b0;
            end else begin
                // RULE1 locked selection blocks new source
                if (acc_hi && !sel_locked && sw_q == SW_IDLE)
                    new_q <= pwdata[oscsw_pkg::NEW_LSB +: 3];
                // RULE20 switch completes
                if (sw_done)
                    cur_q <= new_q;
                if (req_wr)
                    req_q <= 1'b1;
                else if (sw_abort || sw_done)
                    req_q <= 1'b0;
            end
            // RULE1 lock is set-only and needs the monitor
            if (acc_lo && pwdata[oscsw_pkg::LOCK_BIT] && mon_en)
                lock_q <= 1'b1;
            // RULE5 secondary enable bit
            if (acc_lo)
                sec_en_q <= pwdata[oscsw_pkg::SEC_EN_BIT];
        end
    end

    // pll status and clock fail flag
    logic fail_rise;
    assign fail_rise = pin_s.clock_fail_detect & ~fail_seen_q & mon_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_st_q    <= 1'b0;
            fail_q      <= 1'b0;
            fail_seen_q <= 1'b0;
        end else begin
            fail_seen_q <= pin_s.clock_fail_detect;
            // RULE2 RULE3 RULE18 status from live lock, cleared at start
            pll_st_q <= ~sw_start & pin_s.pll_in_lock &
                        clk_d.osc_enable[oscsw_pkg::EN_PLL];
            // RULE4 RULE18 failure sets, write 0 or start clears
            if (fail_rise)
                fail_q <= 1'b1;
            else if (sw_start || (acc_lo && !pwdata[oscsw_pkg::FAIL_BIT]))
                fail_q <= 1'b0;
        end
    end

    // clock_divider_control and rc_tuning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recov_q <= 1'b0;
            doze_q  <= oscsw_pkg::DOZE_RST;
            doze_enable_q <= 1'b0;
            post_q  <= oscsw_pkg::POST_RST;
            trim_q  <= 6'h00;
        end else begin
            if (wr_en && hit_div && pstrb[1]) begin
                recov_q <= pwdata[oscsw_pkg::RECOV_BIT];
                doze_q  <= pwdata[oscsw_pkg::DOZE_LSB +: 3];
                doze_enable_q <= pwdata[oscsw_pkg::DOZE_ENABLE_BIT];
                post_q  <= pwdata[oscsw_pkg::POST_LSB +: 3];
            end
            // RULE7 interrupt recovery wins over a write
            if (recov_q && irq_event)
                doze_enable_q <= 1'b0;
            // RULE11 trim stored as written
            if (wr_en && hit_trm && pstrb[0])
                trim_q <= pwdata[5:0];
        end
    end

    // clock control outputs
    logic [5:0] run_mask;
    logic       switching;
    assign switching = (sw_q == SW_READY) | (sw_q == SW_SETTLE);
    // RULE19 RULE21 current plus target, keep low-power and secondary users
    assign run_mask = src_mask(cur_q) |
        (switching ? new_mask : 6'h00) |
        {2'b00, sec_en_q, pin_s.low_osc_in_use | mon_en, 2'b00};
    always_comb begin
        clk_d.current_source = cur_q;
        clk_d.osc_enable     = run_mask;
        // RULE14 submode only from fuses
        clk_d.primary_submode = pin_s.primary_submode_fuses;
        // RULE8 RULE9 doze ratio only when enabled
        clk_d.doze_shift = doze_enable_q ? doze_q : 3'h0;
        // RULE10 code 7 divides by 256
        clk_d.rc_div_shift = (post_q == 3'h7) ? 4'h8 : {1'b0, post_q};
        clk_d.rc_trim   = trim_q;
        clk_d.switching = switching;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            clk_ctrl <= '0;
        else
            clk_ctrl <= clk_d;
    end

    // read data captured in the setup phase
    logic [15:0] osc_rd, div_rd, trm_rd;
    assign osc_rd = {1'b0, cur_q, 1'b0, new_q, lock_q, 1'b0, pll_st_q,
                     1'b0, fail_q, 1'b0, sec_en_q, req_q};
    assign div_rd = {recov_q, doze_q, doze_enable_q, post_q, 8'h00};
    assign trm_rd = {10'h000, trim_q};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable)
            prdata <= {16'h0000, hit_osc ? osc_rd :
                       hit_div ? div_rd : hit_trm ? trm_rd : 16'h0000};
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lock_blocks;
        (sel_locked && acc_lo && pwdata[0]) |=> !$rose(req_q);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) // RULE1
        else $error("locked selection accepted a switch request");

    property p_pll_clear;
        sw_start |=> !pll_st_q;
    endproperty
    a_pll_clear: assert property (p_pll_clear) // RULE3
        else $error("pll status not cleared at switch start");

    property p_fail_set;
        fail_rise |=> fail_q;
    endproperty
    a_fail_set: assert property (p_fail_set) // RULE4
        else $error("clock fail flag not set");

    property p_sec_run;
        sec_en_q |=> clk_ctrl.osc_enable[oscsw_pkg::EN_SEC];
    endproperty
    a_sec_run: assert property (p_sec_run) // RULE5
        else $error("secondary oscillator stopped while enabled");

    property p_recover;
        (recov_q && irq_event) |=> !doze_enable_q ##1 clk_ctrl.doze_shift == 3'h0;
    endproperty
    a_recover: assert property (p_recover) // RULE7
        else $error("interrupt did not restore 1:1 ratio");

    property p_postdiv;
        (post_q == 3'h7) |=> clk_ctrl.rc_div_shift == 4'h8;
    endproperty
    a_postdiv: assert property (p_postdiv) // RULE10
        else $error("postscaler code 7 not divide by 256");

    property p_disabled;
        (boot_done && !sw_allowed) |=> !req_q;
    endproperty
    a_disabled: assert property (p_disabled) // RULE13
        else $error("switch request set while switching disabled");

    property p_abort;
        sw_abort |=> !req_q && cur_q == $past(cur_q);
    endproperty
    a_abort: assert property (p_abort) // RULE17
        else $error("redundant switch not aborted");

    property p_settle;
        (sw_q == SW_READY && tgt_ready) |=>
            ##9 sw_done ##1 (!req_q && cur_q == new_q);
    endproperty
    a_settle: assert property (p_settle) // RULE20
        else $error("switch not completed after ten cycles");

    property p_unlock;
        (ul_q == UL_IDLE && wr_osc_h) |=> $stable(new_q);
    endproperty
    a_unlock: assert property (p_unlock) // RULE15
        else $error("new source written without unlock");
endmodule // oscsw_top

`default_nettype wire

// ==== verilog/oscsw_pkg.sv ====
// shared constants and carriers of the oscillator switch block
package oscsw_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLK_DIV  = 8'h04;
    localparam logic [7:0] OFS_RC_TUNE  = 8'h08;

    // unlock keys
    localparam logic [7:0] KEY_HIGH_1 = 8'h78;
    localparam logic [7:0] KEY_HIGH_2 = 8'h9a;
    localparam logic [7:0] KEY_LOW_1  = 8'h46;
    localparam logic [7:0] KEY_LOW_2  = 8'h57;

    // oscillator_control field positions
    localparam int CUR_LSB  = 12;
    localparam int NEW_LSB  = 8;
    localparam int LOCK_BIT = 7;
    localparam int PLLS_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int SEC_EN_BIT = 1;
    localparam int REQ_BIT  = 0;
    // clock_divider_control field positions
    localparam int RECOV_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int DOZE_ENABLE_BIT = 11;
    localparam int POST_LSB = 8;

    // values after reset
    localparam logic [2:0] DOZE_RST  = 3'h3;
    localparam logic [2:0] POST_RST  = 3'h1;
    localparam logic [2:0] SRC_RST   = 3'h7;

    // source encodings
    localparam logic [2:0] SRC_RC      = 3'h0;
    localparam logic [2:0] SRC_RC_PLL  = 3'h1;
    localparam logic [2:0] SRC_PRI     = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC     = 3'h4;
    localparam logic [2:0] SRC_LP_OSC  = 3'h5;
    localparam logic [2:0] SRC_LP_RC_DIV = 3'h6;
    localparam logic [2:0] SRC_RC_DIV  = 3'h7;
    localparam logic [1:0] SUB_EXT_CLOCK = 2'h0;

    // cycle counts
    localparam int SETTLE_CYCLES = 10;
    localparam int BOOT_CYCLES   = 5;  // pin filter settles at edge 4

    // oscillator enable mask bit positions
    localparam int EN_RC = 0;
    localparam int EN_LP_RC = 1;
    localparam int EN_LP_OSC = 2;
    localparam int EN_SEC = 3;
    localparam int EN_PRI = 4;
    localparam int EN_PLL = 5;

    // asynchronous inputs from fuses and analog blocks
    typedef struct packed {
        logic [1:0] switch_monitor_fuses;  // 00 monitor, 0x switching
        logic [2:0] initial_source_fuses;
        logic [1:0] primary_submode_fuses;
        logic       osc_startup_done;      // crystal start-up expired
        logic       pll_in_lock;
        logic       clock_fail_detect;     // fail_safe_monitor report
        logic       low_osc_in_use;        // watchdog or real_time_clock
    } oscsw_pins_t;

    // clock control outputs
    typedef struct packed {
        logic [2:0] current_source;
        logic [5:0] osc_enable;            // EN_* positions
        logic [1:0] primary_submode;
        logic [2:0] doze_shift;            // cpu:periph = 1:2^n
        logic [3:0] rc_div_shift;          // rc divide by 2^n
        logic [5:0] rc_trim;               // two's complement
        logic       switching;
    } oscsw_clk_t;
endpackage

// ==== dv/oscsw_top_tb_top.sv ====
// self-checking bench for the oscillator switch block
`timescale 1ns/1ns
`default_nettype none
module oscsw_top_tb_top;
    logic                  pclk, presetn, psel, penable, pwrite, irq_event;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rdata;
    logic [3:0]            pstrb;
    logic                  pready, pslverr, rerr;
    oscsw_pkg::oscsw_pins_t pins;
    oscsw_pkg::oscsw_clk_t  clk_ctrl;
    int                    bad_count, n_checks, k;
    integer                seed;
    logic [31:0]           v;
    oscsw_top oscsw_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .irq_event(irq_event), .clk_ctrl(clk_ctrl));
    // 100 ns clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= d; pstrb <= w ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) bad_count++; // bus timeout
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask
    // unlock high byte, then new source
    task automatic hset(input logic [2:0] src);
        wr(8'h00, 32'h7800, 4'h2);
        wr(8'h00, 32'h9a00, 4'h2);
        wr(8'h00, {21'h0, src, 8'h00}, 4'h2);
    endtask
    // unlock low byte, then low byte value
    task automatic lset(input logic [7:0] b);
        wr(8'h00, 32'h46, 4'h1);
        wr(8'h00, 32'h57, 4'h1);
        wr(8'h00, {24'h0, b}, 4'h1);
    endtask
    // poll until request bit reads 0, bounded
    task automatic waitsw;
        int n;
        n = 0;
        rd(8'h00);
        while (rdata[0] !== 1'b0 && n < 100) begin
            rd(8'h00);
            n++;
        end
        chk("switch_done", 32'h0, {31'h0, rdata[0]});
    endtask
    task automatic rst(input logic [1:0] fz, input logic [2:0] src);
        pins <= '{switch_monitor_fuses: fz, initial_source_fuses: src, default: '0};
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        final_report;
    end
    initial begin
        bad_count = 0; n_checks = 0; seed = 32'h5739dc68;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h0; pwdata = 32'h0; pstrb = 4'h0; irq_event = 1'b0;
        pins = '0;
        rst(2'b00, 3'h5);
        // reset values and source encoding
        rd(8'h00); chk("ctrl_rst", 32'h5500, rdata);
        rd(8'h04); chk("div_rst", 32'h3100, rdata);
        rd(8'h0c); chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0, rdata);
        // trim with corner codes then random
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h1f : (i == 1) ? 32'h20 : $random(seed);
            wr(8'h08, v, 4'h1);
            rd(8'h08); chk("trim", v & 32'h3f, rdata);
            chk("trim_out", v[5:0], clk_ctrl.rc_trim);
        end
        // every postscaler code with random doze settings
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            v = {16'h0, 1'b0, v[14:11], i[2:0], 8'h0};
            wr(8'h04, v, 4'h2);
            rd(8'h04); chk("div", v, rdata);
            chk("doze", v[11] ? v[14:12] : 3'h0, clk_ctrl.doze_shift);
            chk("rc_postscaler", (i == 7) ? 8 : i, clk_ctrl.rc_div_shift);
        end
        // interrupt recovery on and off
        wr(8'h04, 32'hbb00, 4'h2);
        @(posedge pclk) irq_event <= 1'b1;
        @(posedge pclk) irq_event <= 1'b0;
        rd(8'h04); chk("recover_on", 32'hb300, rdata);
        chk("recover_ratio", 32'h0, clk_ctrl.doze_shift);
        wr(8'h04, 32'h0b00, 4'h2);
        @(posedge pclk) irq_event <= 1'b1;
        @(posedge pclk) irq_event <= 1'b0;
        rd(8'h04); chk("recover_off", 32'h0b00, rdata);
        // interrupted unlock is cancelled
        wr(8'h00, 32'h7800, 4'h2);
        wr(8'h00, 32'h9a00, 4'h2);
        wr(8'h08, 32'h0, 4'h1);
        wr(8'h00, 32'h0200, 4'h2);
        rd(8'h00); chk("unlock_cancel", 32'h5500, rdata);
        // redundant switch is aborted
        hset(3'h5); lset(8'h01);
        repeat (4) @(posedge pclk);
        rd(8'h00); chk("redundant", 32'h5500, rdata);
        // switch to primary with pll, waits for lock
        hset(3'h3); lset(8'h03);
        repeat (30) @(posedge pclk);
        rd(8'h00); chk("wait_lock", 32'h5303, rdata);
        chk("switching", 32'h1, clk_ctrl.switching);
        pins.pll_in_lock <= 1'b1;
        waitsw;
        rd(8'h00); chk("pll_done", 32'h3322, rdata);
        chk("cur_out", 32'h3, clk_ctrl.current_source);
        chk("sec_on", 32'h1, clk_ctrl.osc_enable[oscsw_pkg::EN_SEC]);
        // failure report sets the flag
        pins.clock_fail_detect <= 1'b1;
        pins.primary_submode_fuses <= 2'h1;
        repeat (6) @(posedge pclk);
        pins.clock_fail_detect <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(8'h00); chk("fail_flag", 32'h332a, rdata);
        chk("submode", 32'h1, clk_ctrl.primary_submode);
        // switch to plain rc clears pll status and fail flag
        hset(3'h0); lset(8'h0b);
        waitsw;
        rd(8'h00); chk("to_rc", 32'h0002, rdata);
        chk("old_off", 32'hd, clk_ctrl.osc_enable);
        // lock bit freezes new source
        lset(8'h82);
        hset(3'h2);
        rd(8'h00); chk("locked", 32'h0082, rdata);
        lset(8'h83);
        rd(8'h00); chk("locked_req", 32'h0082, rdata);
        // switching disabled by fuses
        rst(2'b11, 3'h2);
        rd(8'h00); chk("fuse_src", 32'h2000, rdata & 32'h7001);
        hset(3'h4); lset(8'h01);
        repeat (20) @(posedge pclk);
        rd(8'h00); chk("no_switch", 32'h2000, rdata & 32'h7001);
        final_report;
    end
endmodule // oscsw_top_tb_top
`default_nettype wire
